// ==== logic/sdt_pkg.sv ====
// Package with the register map, field layout and timing constants of the SDRAM timing block
// Function
// - Count page hits, close page at maximum
// - Wait write close count after writes; reset 14
// - Wait read close count after reads; reset 15
// - Refresh each bank once per interval times 64
// - Zero interval disables refresh; 1-3 never programmed
// - Mask bit drives byte masks one cycle early
// - Bank-to-bank activate gap is 2 or 3
// - Precharge-to-activate gap is 2, 3, 4 or 5
// - Refresh logic alone enforces row active width
// - Write activate follows issue by programmed delay
package sdt_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] TIMING_LO_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] TIMING_HI_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Field layout of memory_timing_config
  // ----------------------------------------
  localparam int MAX_HITS_LSB = 40;
  localparam int WR_WAIT_LSB = 36;
  localparam int RD_WAIT_LSB = 32;
  localparam int REF_LSB = 24;
  localparam int MASK_EARLY_BIT = 20;
  localparam int BANK_GAP_BIT = 16;
  localparam int PRE_GAP_LSB = 12;
  localparam int RAS_WIDTH_LSB = 8;
  localparam int ISSUE_DLY_LSB = 4;
  localparam logic [63:0] WRITABLE_MASK = 64'h0000_3fff_3f11_3377;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [3:0] WR_WAIT_RESET = 4'he;
  localparam logic [3:0] RD_WAIT_RESET = 4'hf;
  localparam logic [63:0] TIMING_RESET =
    {24'h0, WR_WAIT_RESET, RD_WAIT_RESET, 32'h0};

  // ----------------------------------------
  // Timing constants
  // ----------------------------------------
  localparam int REF_SCALE_SHIFT = 6;
  localparam int REF_CNT_W = 12;
  localparam logic [3:0] BANK_GAP_BASE = 4'h1;
  localparam logic [3:0] PRE_GAP_BASE = 4'h1;
  localparam logic [3:0] RAS_WIDTH_BASE = 4'h3;
  localparam int ROW_W = 13;

  // ----------------------------------------
  // SDRAM commands and controller states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5
  } sdt_cmd_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PRE = 7'h02,
    ST_ACT = 7'h04,
    ST_XFER = 7'h08,
    ST_REF_PRE = 7'h10,
    ST_REF_BANK0 = 7'h20,
    ST_REF_BANK1 = 7'h40
  } sdt_state_t;

endpackage : sdt_pkg

// ==== logic/sdt_gap_timer.sv ====
// Down counter that reports when a loaded number of cycles has elapsed
`timescale 1ns/1ps
module sdt_gap_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Load
  input wire logic load,
  input wire logic [3:0] load_val,
  // Status
  output logic done
);
  logic [3:0] cnt_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign done = (cnt_r == 4'h0);
endmodule : sdt_gap_timer

// ==== logic/sdt_timing_ctrl.sv ====
// SDRAM command timing controller with its timing register on an AXI4-Lite slave
`timescale 1ns/1ps
module sdt_timing_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [sdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [sdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Requests from the arbiter
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_bank,
  input wire logic [sdt_pkg::ROW_W-1:0] req_row,
  output logic req_ready,
  // Byte masks from the data path
  input wire logic [1:0] mask_in,
  // SDRAM commands
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic cmd_bank,
  output logic [sdt_pkg::ROW_W-1:0] cmd_row,
  output logic [1:0] dqm
);
  // ----------------------------------------
  // Timing register and field decode
  // ----------------------------------------
  logic [63:0] cfg_r;
  logic [5:0] max_page_hits;
  logic [3:0] write_page_close_wait;
  logic [3:0] read_page_close_wait;
  logic [5:0] refresh_interval_div64;
  logic mask_early_by_one;
  logic bank_to_bank_activate_gap;
  logic [1:0] precharge_to_activate_gap;
  logic [1:0] row_active_min_width;
  logic [2:0] issue_to_row_activate_delay;
  logic [3:0] bank_gap_load;
  logic [3:0] pre_gap_load;
  logic [3:0] ras_width_load;

  assign max_page_hits = cfg_r[sdt_pkg::MAX_HITS_LSB +: 6];
  assign write_page_close_wait = cfg_r[sdt_pkg::WR_WAIT_LSB +: 4];
  assign read_page_close_wait = cfg_r[sdt_pkg::RD_WAIT_LSB +: 4];
  assign refresh_interval_div64 = cfg_r[sdt_pkg::REF_LSB +: 6];
  assign mask_early_by_one = cfg_r[sdt_pkg::MASK_EARLY_BIT];
  assign bank_to_bank_activate_gap = cfg_r[sdt_pkg::BANK_GAP_BIT];
  assign precharge_to_activate_gap = cfg_r[sdt_pkg::PRE_GAP_LSB +: 2];
  assign row_active_min_width = cfg_r[sdt_pkg::RAS_WIDTH_LSB +: 2];
  assign issue_to_row_activate_delay = cfg_r[sdt_pkg::ISSUE_DLY_LSB +: 3];
  assign bank_gap_load = sdt_pkg::BANK_GAP_BASE + {3'h0, bank_to_bank_activate_gap};
  assign pre_gap_load = sdt_pkg::PRE_GAP_BASE + {2'h0, precharge_to_activate_gap};
  assign ras_width_load = sdt_pkg::RAS_WIDTH_BASE + {2'h0, row_active_min_width};

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [sdt_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic wr_lo;
  logic wr_hi;
  logic [31:0] wr_bmask;
  logic [63:0] cfg_nxt;
  logic rd_fire;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [31:0] status_word;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_lo = wr_fire && (aw_addr_r == sdt_pkg::TIMING_LO_ADDR);
  assign wr_hi = wr_fire && (aw_addr_r == sdt_pkg::TIMING_HI_ADDR);
  assign wr_bmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign cfg_nxt = wr_lo ? {cfg_r[63:32], (cfg_r[31:0] & ~wr_bmask) | (w_data_r & wr_bmask)} :
                   wr_hi ? {(cfg_r[63:32] & ~wr_bmask) | (w_data_r & wr_bmask), cfg_r[31:0]} :
                   cfg_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  assign s_axi_arready = !rvalid_r;
  assign rd_fire = s_axi_arvalid && !rvalid_r;
  assign rd_ok = (s_axi_araddr == sdt_pkg::TIMING_LO_ADDR) ||
                 (s_axi_araddr == sdt_pkg::TIMING_HI_ADDR) ||
                 (s_axi_araddr == sdt_pkg::STATUS_ADDR);
  assign rd_mux = (s_axi_araddr == sdt_pkg::TIMING_LO_ADDR) ? cfg_r[31:0] :
                  (s_axi_araddr == sdt_pkg::TIMING_HI_ADDR) ? cfg_r[63:32] :
                  (s_axi_araddr == sdt_pkg::STATUS_ADDR) ? status_word : 32'h0;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= sdt_pkg::RESP_OKAY;
      cfg_r <= sdt_pkg::TIMING_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wr_lo || wr_hi || aw_addr_r == sdt_pkg::STATUS_ADDR) ?
                   sdt_pkg::RESP_OKAY : sdt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      cfg_r <= cfg_nxt & sdt_pkg::WRITABLE_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= sdt_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? sdt_pkg::RESP_OKAY : sdt_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Refresh interval counter
  // ----------------------------------------
  logic [sdt_pkg::REF_CNT_W-1:0] ref_cnt_r;
  logic [sdt_pkg::REF_CNT_W-1:0] ref_period;
  logic ref_enable;
  logic ref_tick;
  logic ref_pend_r;
  logic ref_done;

  assign ref_period = {refresh_interval_div64, 6'h0};
  assign ref_enable = (refresh_interval_div64 != 6'h0);
  assign ref_tick = ref_enable && (ref_cnt_r >= ref_period - 12'h1);

  always_ff @(posedge core_clk) begin
    if (rst || !ref_enable) begin
      ref_cnt_r <= '0;
      ref_pend_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_tick ? '0 : ref_cnt_r + 12'h1;
      ref_pend_r <= ref_tick || (ref_pend_r && !ref_done);
    end
  end

  // ----------------------------------------
  // Gap timers
  // ----------------------------------------
  sdt_pkg::sdt_state_t state_r;
  sdt_pkg::sdt_state_t state_nxt;
  logic issue_pre;
  logic issue_act;
  logic issue_ref;
  logic issue_xfer;
  logic cmd_bank_sel;
  logic [1:0] pre_done;
  logic [1:0] ras_done;
  logic [1:0] close_done;
  logic bank_gap_done;
  logic issue_dly_done;
  logic accept;
  logic tgt_write_r;

  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++) begin : g_bank
      sdt_gap_timer u_pre_gap (
        .core_clk(core_clk),
        .rst(rst),
        .load(issue_pre && cmd_bank_sel == gb[0]),
        .load_val(pre_gap_load),
        .done(pre_done[gb])
      );
      sdt_gap_timer u_ras_width (
        .core_clk(core_clk),
        .rst(rst),
        .load(issue_ref && cmd_bank_sel == gb[0]),
        .load_val(ras_width_load),
        .done(ras_done[gb])
      );
      sdt_gap_timer u_close_wait (
        .core_clk(core_clk),
        .rst(rst),
        .load(issue_xfer && cmd_bank_sel == gb[0]),
        .load_val(tgt_write_r ? write_page_close_wait : read_page_close_wait),
        .done(close_done[gb])
      );
    end
  endgenerate

  sdt_gap_timer u_bank_gap (
    .core_clk(core_clk),
    .rst(rst),
    .load(issue_act || issue_ref),
    .load_val(bank_gap_load),
    .done(bank_gap_done)
  );

  sdt_gap_timer u_issue_dly (
    .core_clk(core_clk),
    .rst(rst),
    .load(accept),
    .load_val(req_write ? {1'b0, issue_to_row_activate_delay} : 4'h0),
    .done(issue_dly_done)
  );

  // ----------------------------------------
  // Bank state and command sequencing
  // ----------------------------------------
  logic [1:0] open_r;
  logic [1:0] close_pend_r;
  logic [sdt_pkg::ROW_W-1:0] row_r [2];
  logic [5:0] hits_r [2];
  logic tgt_bank_r;
  logic [sdt_pkg::ROW_W-1:0] tgt_row_r;
  logic [1:0] hit_limit;
  logic page_hit;
  logic auto_close;
  logic auto_bank;
  logic ref_pre_bank;

  assign hit_limit[0] = (hits_r[0] >= max_page_hits);
  assign hit_limit[1] = (hits_r[1] >= max_page_hits);
  assign req_ready = (state_r == sdt_pkg::ST_IDLE) && !ref_pend_r;
  assign accept = req_valid && req_ready;
  assign page_hit = open_r[req_bank] && (row_r[req_bank] == req_row) && !hit_limit[req_bank];
  assign auto_bank = (close_pend_r[0] && close_done[0]) ? 1'b0 : 1'b1;
  assign auto_close = (state_r == sdt_pkg::ST_IDLE) && !ref_pend_r && !req_valid &&
                      close_pend_r[auto_bank] && close_done[auto_bank];
  assign ref_pre_bank = open_r[0] ? 1'b0 : 1'b1;
  assign ref_done = (state_r == sdt_pkg::ST_REF_BANK1) && issue_ref;

  assign issue_pre = auto_close ||
    ((state_r == sdt_pkg::ST_PRE) && ras_done[tgt_bank_r]) ||
    ((state_r == sdt_pkg::ST_REF_PRE) && (open_r != 2'h0) && ras_done[ref_pre_bank]);
  assign issue_act = (state_r == sdt_pkg::ST_ACT) && issue_dly_done && bank_gap_done &&
                     pre_done[tgt_bank_r];
  assign issue_xfer = (state_r == sdt_pkg::ST_XFER);
  assign issue_ref = ((state_r == sdt_pkg::ST_REF_BANK0) && pre_done[0] && bank_gap_done) ||
                     ((state_r == sdt_pkg::ST_REF_BANK1) && pre_done[1] && bank_gap_done);
  assign cmd_bank_sel = auto_close ? auto_bank :
                        (state_r == sdt_pkg::ST_REF_PRE) ? ref_pre_bank :
                        (state_r == sdt_pkg::ST_REF_BANK0) ? 1'b0 :
                        (state_r == sdt_pkg::ST_REF_BANK1) ? 1'b1 : tgt_bank_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sdt_pkg::ST_IDLE: begin
        if (ref_pend_r) begin
          state_nxt = sdt_pkg::ST_REF_PRE;
        end else if (accept) begin
          state_nxt = page_hit ? sdt_pkg::ST_XFER :
                      open_r[req_bank] ? sdt_pkg::ST_PRE : sdt_pkg::ST_ACT;
        end
      end
      sdt_pkg::ST_PRE: state_nxt = issue_pre ? sdt_pkg::ST_ACT : state_r;
      sdt_pkg::ST_ACT: state_nxt = issue_act ? sdt_pkg::ST_XFER : state_r;
      sdt_pkg::ST_XFER: state_nxt = sdt_pkg::ST_IDLE;
      sdt_pkg::ST_REF_PRE: state_nxt = (open_r == 2'h0) ? sdt_pkg::ST_REF_BANK0 : state_r;
      sdt_pkg::ST_REF_BANK0: state_nxt = issue_ref ? sdt_pkg::ST_REF_BANK1 : state_r;
      sdt_pkg::ST_REF_BANK1: state_nxt = issue_ref ? sdt_pkg::ST_IDLE : state_r;
      default: state_nxt = sdt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= sdt_pkg::ST_IDLE;
      tgt_bank_r <= 1'b0;
      tgt_write_r <= 1'b0;
      tgt_row_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        tgt_bank_r <= req_bank;
        tgt_write_r <= req_write;
        tgt_row_r <= req_row;
      end
    end
  end

  genvar bk;
  generate
    for (bk = 0; bk < 2; bk++) begin : g_page
      always_ff @(posedge core_clk) begin
        if (rst) begin
          open_r[bk] <= 1'b0;
          close_pend_r[bk] <= 1'b0;
          row_r[bk] <= '0;
          hits_r[bk] <= 6'h0;
        end else if (cmd_bank_sel == bk[0]) begin
          if (issue_pre) begin
            open_r[bk] <= 1'b0;
            close_pend_r[bk] <= 1'b0;
          end else if (issue_act) begin
            open_r[bk] <= 1'b1;
            row_r[bk] <= tgt_row_r;
            hits_r[bk] <= 6'h0;
          end else if (issue_xfer) begin
            close_pend_r[bk] <= 1'b1;
            hits_r[bk] <= (hits_r[bk] == 6'h3f) ? hits_r[bk] : hits_r[bk] + 6'h1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Command and mask outputs
  // ----------------------------------------
  logic cmd_valid_r;
  logic [2:0] cmd_code_r;
  logic cmd_bank_r;
  logic [sdt_pkg::ROW_W-1:0] cmd_row_r;
  logic [1:0] mask_stage_r;
  logic [1:0] dqm_r;
  logic [2:0] cmd_code_nxt;

  assign cmd_code_nxt = issue_pre ? sdt_pkg::CMD_PRE :
                        issue_act ? sdt_pkg::CMD_ACT :
                        issue_ref ? sdt_pkg::CMD_REF :
                        tgt_write_r ? sdt_pkg::CMD_WR : sdt_pkg::CMD_RD;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_valid_r <= 1'b0;
      cmd_code_r <= 3'h0;
      cmd_bank_r <= 1'b0;
      cmd_row_r <= '0;
      mask_stage_r <= 2'h0;
      dqm_r <= 2'h0;
    end else begin
      cmd_valid_r <= issue_pre || issue_act || issue_ref || issue_xfer;
      cmd_code_r <= cmd_code_nxt;
      cmd_bank_r <= cmd_bank_sel;
      cmd_row_r <= tgt_row_r;
      mask_stage_r <= mask_in;
      dqm_r <= mask_early_by_one ? mask_in : mask_stage_r;
    end
  end

  assign cmd_valid = cmd_valid_r;
  assign cmd_code = cmd_code_r;
  assign cmd_bank = cmd_bank_r;
  assign cmd_row = cmd_row_r;
  assign dqm = dqm_r;
  assign status_word = {20'h0, ref_pend_r, close_pend_r, open_r, state_r};
endmodule : sdt_timing_ctrl

// ==== dv/sdt_timing_checker.sv ====
// Checker of bus holding, command spacing and timing register read-back
`timescale 1ns/1ps
module sdt_timing_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire logic [sdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Requests and commands
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_bank
);
  // ----
  // Helper logic
  // ----
  logic [sdt_pkg::ADDR_W-1:0] rd_addr_r;
  logic [3:0] ref_age_r;
  logic ref_bank_r;
  wire is_ref = cmd_valid && cmd_code == sdt_pkg::CMD_REF;
  wire act_ref = is_ref || (cmd_valid && cmd_code == sdt_pkg::CMD_ACT);
  wire is_pre = cmd_valid && cmd_code == sdt_pkg::CMD_PRE;
  wire is_xfer = cmd_valid && (cmd_code == sdt_pkg::CMD_RD || cmd_code == sdt_pkg::CMD_WR);
  wire rd_hi = rd_addr_r == sdt_pkg::TIMING_HI_ADDR;
  wire rd_cfg = rd_hi || rd_addr_r == sdt_pkg::TIMING_LO_ADDR;
  wire [63:0] rsv = ~sdt_pkg::WRITABLE_MASK;
  wire [31:0] rsv_word = rd_hi ? rsv[63:32] : rsv[31:0];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_addr_r <= '0;
      ref_age_r <= 4'hf;
      ref_bank_r <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
      if (is_ref) begin
        ref_age_r <= 4'h1;
        ref_bank_r <= cmd_bank;
      end else if (ref_age_r != 4'hf) begin
        ref_age_r <= ref_age_r + 4'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  reserved_zero_a: assert property (
    s_axi_rvalid && rd_cfg |-> (s_axi_rdata & rsv_word) == 32'h0)
    else $error("reserved bits read nonzero");
  bank_gap_a: assert property (act_ref |=> !act_ref)
    else $error("activate spacing too short");
  pre_gap_a: assert property (
    is_pre |=> !(act_ref && cmd_bank == $past(cmd_bank)))
    else $error("precharge spacing too short");
  ref_pair_a: assert property (
    is_ref && !cmd_bank |-> ##[2:40] (is_ref && cmd_bank))
    else $error("second bank not refreshed");
  ras_width_a: assert property (
    is_pre && cmd_bank == ref_bank_r |-> ref_age_r >= 4'h4)
    else $error("precharge too soon after refresh");
  act_xfer_a: assert property (cmd_valid && cmd_code == sdt_pkg::CMD_ACT |=> is_xfer)
    else $error("no transfer after activate");
  req_done_a: assert property (req_valid && req_ready |-> ##[2:60] is_xfer)
    else $error("request not served");
endmodule : sdt_timing_checker
bind sdt_timing_ctrl sdt_timing_checker u_chk (.core_clk, .rst, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .req_valid, .req_ready, .cmd_valid, .cmd_code, .cmd_bank);

// ==== dv/sdt_sdram_model.sv ====
// Behavioural model of the SDRAM banks that counts and polices commands
`timescale 1ns/1ps
module sdt_sdram_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Commands
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_bank,
  // Counters
  output logic [15:0] act_count,
  output logic [15:0] ref_count,
  output logic [15:0] bad_count
);
  logic [1:0] open_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      open_r <= 2'h0;
      act_count <= 16'h0;
      ref_count <= 16'h0;
      bad_count <= 16'h0;
    end else if (cmd_valid) begin
      case (cmd_code)
        sdt_pkg::CMD_ACT: begin
          act_count <= act_count + 16'h1;
          open_r[cmd_bank] <= 1'b1;
          if (open_r[cmd_bank]) bad_count <= bad_count + 16'h1;
        end
        sdt_pkg::CMD_RD, sdt_pkg::CMD_WR: begin
          if (!open_r[cmd_bank]) bad_count <= bad_count + 16'h1;
        end
        sdt_pkg::CMD_PRE: open_r[cmd_bank] <= 1'b0;
        sdt_pkg::CMD_REF: begin
          ref_count <= ref_count + 16'h1;
          if (open_r[cmd_bank]) bad_count <= bad_count + 16'h1;
        end
        default: bad_count <= bad_count + 16'h1;
      endcase
    end
  end
endmodule : sdt_sdram_model

// ==== dv/tb_top.sv ====
// Self-checking bench of the SDRAM timing controller
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [sdt_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, s_axi_rdata_q;
  logic [3:0] s_axi_wstrb = '0, wv;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_bank = 1'b0;
  logic [sdt_pkg::ROW_W-1:0] req_row = '0, cmd_row;
  logic [1:0] mask_in = 2'h0, m1 = 2'h0, m2 = 2'h0, dqm, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_ready;
  logic cmd_valid, cmd_bank;
  logic [2:0] cmd_code;
  logic [15:0] act_count, ref_count, bad_count, snap;
  int fails = 0, check_count = 0, cyc = 0, t_acc = 0, t_act = 0, t_pre = 0, t_xfer = 0;
  int t_ref0 = 0, t_ref0_old = 0, ref_gap = 0;
  int lat [0:5];
  sdt_timing_ctrl u_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .req_valid, .req_write, .req_bank, .req_row, .req_ready,
    .mask_in, .cmd_valid, .cmd_code, .cmd_bank, .cmd_row, .dqm);
  sdt_sdram_model u_mem (.core_clk, .rst, .cmd_valid, .cmd_code, .cmd_bank, .act_count,
    .ref_count, .bad_count);
  initial forever #5 core_clk = ~core_clk;
  // ----
  // Monitor and tasks
  // ----
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    mask_in <= cyc[1:0];
    m1 <= mask_in;
    m2 <= m1;
    if (cmd_valid) begin
      if (cmd_code == sdt_pkg::CMD_ACT) t_act = cyc;
      if (cmd_code == sdt_pkg::CMD_ACT) check(cmd_row === req_row, "activate row");
      if (cmd_code == sdt_pkg::CMD_PRE) t_pre = cyc;
      if (cmd_code == sdt_pkg::CMD_RD || cmd_code == sdt_pkg::CMD_WR) t_xfer = cyc;
      if (cmd_code == sdt_pkg::CMD_REF && cmd_bank) ref_gap = cyc - t_ref0;
      if (cmd_code == sdt_pkg::CMD_REF && !cmd_bank) begin
        t_ref0_old = t_ref0;
        t_ref0 = cyc;
      end
    end
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      fails++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
    logic aw, w, b;
    logic [1:0] resp;
    b = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge core_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check(resp === exp, "write response");
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
    logic ar, r;
    logic [1:0] resp;
    r = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(negedge core_clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      resp = s_axi_rresp;
      s_axi_rdata_q = s_axi_rdata;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(resp === exp, "read response");
    if (exp == sdt_pkg::RESP_OKAY) check(s_axi_rdata_q === d, "read data");
  endtask : axi_read
  task automatic cfg(input logic hi, input logic [31:0] d);
    axi_write(hi ? sdt_pkg::TIMING_HI_ADDR : sdt_pkg::TIMING_LO_ADDR, d, sdt_pkg::RESP_OKAY);
  endtask : cfg
  task automatic do_req(input logic w, input logic bk, input int row);
    logic hs;
    hs = 1'b0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_bank <= bk;
    req_row <= row[sdt_pkg::ROW_W-1:0];
    while (!hs) begin
      @(negedge core_clk);
      hs = req_ready;
      @(posedge core_clk);
    end
    t_acc = cyc;
    req_valid <= 1'b0;
    while (t_xfer <= t_acc) @(negedge core_clk);
  endtask : do_req
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    axi_read(sdt_pkg::TIMING_LO_ADDR, 32'h0, sdt_pkg::RESP_OKAY);
    axi_read(sdt_pkg::TIMING_HI_ADDR, {24'h0, 4'he, 4'hf}, sdt_pkg::RESP_OKAY);
    axi_read(4'hc, 32'h0, sdt_pkg::RESP_SLVERR);
    axi_write(4'hc, 32'hffff_ffff, sdt_pkg::RESP_SLVERR);
    cfg(1'b1, 32'hffff_ffff);
    axi_read(sdt_pkg::TIMING_HI_ADDR, sdt_pkg::WRITABLE_MASK[63:32], sdt_pkg::RESP_OKAY);
    cfg(1'b0, 32'hffff_ffff);
    axi_read(sdt_pkg::TIMING_LO_ADDR, sdt_pkg::WRITABLE_MASK[31:0], sdt_pkg::RESP_OKAY);
    cfg(1'b1, {24'h0, 4'he, 4'hf});
    for (int d = 1; d <= 5; d++) begin
      cfg(1'b0, 32'(d) << sdt_pkg::ISSUE_DLY_LSB);
      repeat (40) @(posedge core_clk);
      do_req(1'b1, 1'b0, d);
      lat[d] = t_act - t_acc;
      if (d > 1) check(lat[d] - lat[d-1] == 1, "issue delay step");
    end
    for (int k = 0; k < 4; k++) begin
      wv = k[1] ? 4'hb : 4'h6;
      cfg(1'b1, {18'h0, 6'h3f, k[0] ? wv : 4'hf, k[0] ? 4'hf : wv});
      repeat (40) @(posedge core_clk);
      do_req(k[0], 1'b1, 7);
      repeat (30) @(posedge core_clk);
      lat[k] = t_pre - t_xfer;
      if (k > 1) check(lat[k] - lat[k-2] == 5, "close wait");
    end
    for (int m = 0; m < 2; m++) begin
      cfg(1'b1, {18'h0, (m != 0) ? 6'h3f : 6'h01, 8'hff});
      repeat (40) @(posedge core_clk);
      snap = act_count;
      repeat (6) do_req(1'b0, 1'b0, 9);
      if (m != 0) check(act_count - snap == 16'h1, "page kept open");
      else check(act_count - snap >= 16'h2, "page hit limit");
    end
    cfg(1'b0, 32'h0000_2000);
    do_req(1'b0, 1'b0, 9);
    do_req(1'b0, 1'b0, 10);
    check(t_act - t_pre >= 4, "precharge gap");
    for (int g = 0; g < 2; g++) begin
      cfg(1'b0, 32'h0400_0000 | (32'(g) << sdt_pkg::BANK_GAP_BIT));
      repeat (900) @(posedge core_clk);
      check(t_ref0 - t_ref0_old == 256, "refresh interval");
      check(ref_gap >= 2 + g, "bank gap");
    end
    cfg(1'b0, 32'h0);
    repeat (300) @(posedge core_clk);
    snap = ref_count;
    repeat (600) @(posedge core_clk);
    check(ref_count === snap, "refresh off");
    check(bad_count === 16'h0, "command order");
    for (int b = 0; b < 2; b++) begin
      cfg(1'b0, 32'(b) << sdt_pkg::MASK_EARLY_BIT);
      repeat (3) @(posedge core_clk);
      repeat (4) begin
        @(negedge core_clk);
        check(dqm === ((b != 0) ? m1 : m2), "mask timing");
      end
    end
    report_and_stop();
  end
endmodule : tb_top
